// ---- rtl/csf_pkg.sv ----
// constants and types shared by the charger status and fault register bank
package csf_pkg;

    // register offsets
    localparam logic [7:0] CSF_ADDR_STATE_FLAGS = 8'h0b;
    localparam logic [7:0] CSF_ADDR_THERM_BATT = 8'h0c;
    localparam logic [7:0] CSF_ADDR_FAULTS = 8'h0d;
    localparam logic [7:0] CSF_ADDR_SHORT_CFG = 8'h10;

    // charger_state_flags field positions
    localparam int CSF_POS_OVERVOLT = 7;
    localparam int CSF_POS_VIN_VALID = 6;
    localparam int CSF_POS_VIN_LIMIT = 5;
    localparam int CSF_POS_HEAT_LIMIT = 4;
    localparam int CSF_POS_DONE = 3;

    // thermal_battery_state field positions
    localparam int CSF_POS_ZONE_LSB = 5;
    localparam int CSF_POS_RECHARGE = 3;

    // sticky_fault_flags field positions and writable mask
    localparam int CSF_POS_SHORT = 3;
    localparam int CSF_POS_HOT_LOW = 1;
    localparam int CSF_POS_HOT_HIGH = 0;
    localparam logic [7:0] CSF_FAULT_MASK = 8'h0b;

    // short_detect_config field positions, mask and reset values
    localparam int CSF_POS_TIMEOUT_LSB = 5;
    localparam int CSF_POS_VOLT_LSB = 0;
    localparam logic [7:0] CSF_SHORT_CFG_MASK = 8'he7;
    localparam logic [2:0] CSF_TIMEOUT_RESET = 3'h4;
    localparam logic [2:0] CSF_VOLT_RESET = 3'h4;

    // short threshold in millivolts: base plus code times step
    localparam logic [11:0] CSF_SHORT_MV_BASE = 12'h7d0;
    localparam logic [11:0] CSF_SHORT_MV_STEP = 12'h064;

    // one second at the 100 MHz clock
    localparam int CSF_CLOCK_HZ = 100_000_000;
    localparam int CSF_SECOND_CYCLES = CSF_CLOCK_HZ;

    typedef enum logic [2:0] {
        CSF_CHG_OFF = 3'h0,
        CSF_CHG_TRICKLE = 3'h1,
        CSF_CHG_FAST_CC = 3'h2,
        CSF_CHG_FAST_CV = 3'h3,
        CSF_CHG_COMPLETE = 3'h4,
        CSF_CHG_LDO = 3'h5,
        CSF_CHG_TIMER_EXP = 3'h6,
        CSF_CHG_BATT_DET = 3'h7
    } csf_chg_state_t;

    // timeout code to seconds: 1, 2, 4, 10, 30, 60, 120, 180
    function automatic logic [7:0] csf_timeout_sec(input logic [2:0] code);
        logic [7:0] sec;
        sec = 8'h01;
        unique case (code)
            3'h0: sec = 8'h01;
            3'h1: sec = 8'h02;
            3'h2: sec = 8'h04;
            3'h3: sec = 8'h0a;
            3'h4: sec = 8'h1e;
            3'h5: sec = 8'h3c;
            3'h6: sec = 8'h78;
            3'h7: sec = 8'hb4;
        endcase
        return sec;
    endfunction

endpackage

// ---- rtl/csf_timer_if.sv ----
// link between the register bank and its battery-short timer
`timescale 1ns/1ps
`default_nettype none
interface csf_timer_if;
    logic arm;
    logic [7:0] limit_sec;
    logic expired;

    modport ctl (output arm, output limit_sec, input expired);
    modport tmr (input arm, input limit_sec, output expired);
endinterface
`default_nettype wire

// ---- rtl/csf_short_timer.sv ----
// seconds timer that qualifies a battery short
`timescale 1ns/1ps
`default_nettype none
module csf_short_timer
    import csf_pkg::*;
#(
    parameter int SECOND_CYCLES = CSF_SECOND_CYCLES
) (
    input wire logic clock,
    input wire logic rst_n,
    csf_timer_if.tmr tif
);
    logic [31:0] prescale;
    logic [7:0] seconds;
    logic done;
    logic expired;
    logic [31:0] next_prescale;
    logic [7:0] next_seconds;
    logic next_done;
    logic next_expired;

    // dropping arm restarts the whole wait, so a brief recovery resets it
    always_comb begin
        next_prescale = prescale;
        next_seconds = seconds;
        next_done = done;
        next_expired = 1'b0;
        if (!tif.arm) begin
            next_prescale = 32'h0;
            next_seconds = 8'h00;
            next_done = 1'b0;
        end else if (!done) begin
            if (prescale == 32'(SECOND_CYCLES - 1)) begin
                next_prescale = 32'h0;
                next_seconds = seconds + 8'h01;
                if (seconds + 8'h01 >= tif.limit_sec) begin
                    next_done = 1'b1;
                    next_expired = 1'b1;
                end
            end else begin
                next_prescale = prescale + 32'h1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            prescale <= 32'h0;
            seconds <= 8'h00;
            done <= 1'b0;
            expired <= 1'b0;
        end else begin
            prescale <= next_prescale;
            seconds <= next_seconds;
            done <= next_done;
            expired <= next_expired;
        end
    end

    assign tif.expired = expired;
endmodule
`default_nettype wire

// ---- rtl/csf_charger_status_fault_regs.sv ----
// charger status, sticky fault and battery-short configuration registers
`timescale 1ns/1ps
`default_nettype none

module csf_charger_status_fault_regs
    import csf_pkg::*;
#(
    parameter int SECOND_CYCLES = CSF_SECOND_CYCLES
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic input_overvoltage_flag,
    input wire logic input_valid_flag,
    input wire logic input_current_limited_flag,
    input wire logic die_heat_limited_flag,
    input wire logic [2:0] charger_state,
    input wire logic charge_cycle_end,
    input wire logic [2:0] thermistor_zone_field,
    input wire logic [2:0] battery_class,
    input wire logic auto_recharge_disable,
    input wire logic below_recharge_level,
    input wire logic [11:0] battery_mv,
    input wire logic lower_overheat_event,
    input wire logic upper_overheat_event,
    input wire logic supply_power_lost,
    input wire logic mode_change_irq_enable,
    output logic mode_change_irq,
    output logic shorted_cell_fault,
    output logic [2:0] short_timeout_select,
    output logic [2:0] short_voltage_select
);
    csf_timer_if tif ();

    // sampled status inputs
    logic overvolt;
    logic vin_valid;
    logic vin_limited;
    logic heat_limited;
    logic [2:0] chg_state;
    logic [2:0] zone;
    logic [2:0] batt_class;
    logic recharge_needed;
    logic [2:0] next_chg_state;
    logic next_recharge_needed;

    // charge-done latch
    logic charge_done_flag;
    logic next_charge_done_flag;

    // faults and configuration
    logic [7:0] faults;
    logic [7:0] next_faults;
    logic [2:0] timeout_sel;
    logic [2:0] volt_sel;
    logic [2:0] next_timeout_sel;
    logic [2:0] next_volt_sel;

    // short detection
    logic short_arm;
    logic [7:0] short_limit;
    logic next_short_arm;
    logic [7:0] next_short_limit;
    logic [11:0] short_mv;
    logic charging;

    // interrupt and read path
    logic irq;
    logic next_irq;
    logic [7:0] rdata;
    logic [7:0] next_rdata;

    logic wr_faults;
    logic wr_cfg;

    assign wr_faults = reg_wr && (reg_addr == CSF_ADDR_FAULTS);
    assign wr_cfg = reg_wr && (reg_addr == CSF_ADDR_SHORT_CFG);

    // ---- status sampling
    always_comb begin
        next_chg_state = charger_state;
        next_recharge_needed = 1'b0;
        // the flag has meaning only in complete with auto recharge off
        if (auto_recharge_disable &&
            charger_state == CSF_CHG_COMPLETE) begin
            next_recharge_needed = below_recharge_level;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            overvolt <= 1'b0;
            vin_valid <= 1'b0;
            vin_limited <= 1'b0;
            heat_limited <= 1'b0;
            chg_state <= CSF_CHG_OFF;
            zone <= 3'h0;
            batt_class <= 3'h0;
            recharge_needed <= 1'b0;
        end else begin
            overvolt <= input_overvoltage_flag;
            vin_valid <= input_valid_flag;
            vin_limited <= input_current_limited_flag;
            heat_limited <= die_heat_limited_flag;
            chg_state <= next_chg_state;
            zone <= thermistor_zone_field;
            batt_class <= battery_class;
            recharge_needed <= next_recharge_needed;
        end
    end

    // ---- charge-done latch
    // held across a recharge-level drop; released only when a new
    // charge phase begins, so software still sees the last completion
    always_comb begin
        next_charge_done_flag = charge_done_flag;
        if (charger_state == CSF_CHG_TRICKLE ||
            charger_state == CSF_CHG_FAST_CC ||
            charger_state == CSF_CHG_FAST_CV) begin
            next_charge_done_flag = 1'b0;
        end
        if (charge_cycle_end) begin
            next_charge_done_flag = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            charge_done_flag <= 1'b0;
        end else begin
            charge_done_flag <= next_charge_done_flag;
        end
    end

    // ---- sticky faults
    // order matters: host clear, then power-loss clear, then sets, so an
    // event in the clearing cycle is kept, except a short expiry during power loss
    always_comb begin
        next_faults = faults;
        if (wr_faults) begin
            next_faults = faults & ~(reg_wdata & CSF_FAULT_MASK);
        end
        if (supply_power_lost) begin
            next_faults = 8'h00;
        end
        if (tif.expired && !supply_power_lost) begin
            next_faults[CSF_POS_SHORT] = 1'b1;
        end
        if (lower_overheat_event) begin
            next_faults[CSF_POS_HOT_LOW] = 1'b1;
        end
        if (upper_overheat_event) begin
            next_faults[CSF_POS_HOT_HIGH] = 1'b1;
        end
        next_faults = next_faults & CSF_FAULT_MASK;
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            faults <= 8'h00;
        end else begin
            faults <= next_faults;
        end
    end

    // ---- short detection configuration
    always_comb begin
        next_timeout_sel = timeout_sel;
        next_volt_sel = volt_sel;
        if (wr_cfg) begin
            // bits 4:3 are not stored
            next_timeout_sel = reg_wdata[CSF_POS_TIMEOUT_LSB +: 3];
            next_volt_sel = reg_wdata[CSF_POS_VOLT_LSB +: 3];
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            timeout_sel <= CSF_TIMEOUT_RESET;
            volt_sel <= CSF_VOLT_RESET;
        end else begin
            timeout_sel <= next_timeout_sel;
            volt_sel <= next_volt_sel;
        end
    end

    // ---- short qualification
    assign short_mv = CSF_SHORT_MV_BASE +
        12'(volt_sel) * CSF_SHORT_MV_STEP;
    assign charging = (chg_state == CSF_CHG_TRICKLE) ||
        (chg_state == CSF_CHG_FAST_CC) ||
        (chg_state == CSF_CHG_FAST_CV);

    // arm is registered, which adds one cycle to the qualifying time;
    // that is negligible against a one-second minimum
    always_comb begin
        next_short_arm = charging && (battery_mv < short_mv);
        next_short_limit = csf_timeout_sec(timeout_sel);
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            short_arm <= 1'b0;
            short_limit <= csf_timeout_sec(CSF_TIMEOUT_RESET);
        end else begin
            short_arm <= next_short_arm;
            short_limit <= next_short_limit;
        end
    end

    assign tif.arm = short_arm;
    assign tif.limit_sec = short_limit;

    csf_short_timer #(
        .SECOND_CYCLES(SECOND_CYCLES)
    ) u_short_timer (
        .clock(clock),
        .rst_n(rst_n),
        .tif(tif)
    );

    // ---- mode change interrupt
    // one-cycle pulse per change of the sampled state
    always_comb begin
        next_irq = mode_change_irq_enable &&
            (next_chg_state != chg_state);
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= next_irq;
        end
    end

    // ---- read path
    // read data are registered; unmapped offsets return zero
    always_comb begin
        next_rdata = rdata;
        if (reg_rd) begin
            next_rdata = 8'h00;
            unique case (reg_addr)
                CSF_ADDR_STATE_FLAGS: begin
                    next_rdata[CSF_POS_OVERVOLT] = overvolt;
                    next_rdata[CSF_POS_VIN_VALID] = vin_valid;
                    next_rdata[CSF_POS_VIN_LIMIT] = vin_limited;
                    next_rdata[CSF_POS_HEAT_LIMIT] = heat_limited;
                    next_rdata[CSF_POS_DONE] = charge_done_flag;
                    next_rdata[2:0] = chg_state;
                end
                CSF_ADDR_THERM_BATT: begin
                    next_rdata[CSF_POS_ZONE_LSB +: 3] = zone;
                    next_rdata[CSF_POS_RECHARGE] = recharge_needed;
                    next_rdata[2:0] = batt_class;
                end
                CSF_ADDR_FAULTS: begin
                    next_rdata = faults;
                end
                CSF_ADDR_SHORT_CFG: begin
                    next_rdata[CSF_POS_TIMEOUT_LSB +: 3] = timeout_sel;
                    next_rdata[CSF_POS_VOLT_LSB +: 3] = volt_sel;
                end
                default: begin
                    next_rdata = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rdata <= 8'h00;
        end else begin
            rdata <= next_rdata;
        end
    end

    // ---- outputs
    assign reg_rdata = rdata;
    assign mode_change_irq = irq;
    assign shorted_cell_fault = faults[CSF_POS_SHORT];
    assign short_timeout_select = timeout_sel;
    assign short_voltage_select = volt_sel;
endmodule
`default_nettype wire

// ---- verif/csf_regs_asserts.sv ----
// checker for the charger status and fault register bank
`timescale 1ns/1ps
`default_nettype none
module csf_regs_asserts
    import csf_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [2:0] charger_state,
    input wire logic supply_power_lost,
    input wire logic mode_change_irq_enable,
    input wire logic mode_change_irq,
    input wire logic shorted_cell_fault,
    input wire logic [2:0] short_timeout_select,
    input wire logic [2:0] short_voltage_select
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    logic rd_flt, rd_cfg, rd_bad, wr_cfg, clr_sh;
    assign rd_flt = reg_rd && reg_addr == CSF_ADDR_FAULTS;
    assign rd_cfg = reg_rd && reg_addr == CSF_ADDR_SHORT_CFG;
    assign rd_bad = reg_rd && !(reg_addr inside {CSF_ADDR_STATE_FLAGS,
        CSF_ADDR_THERM_BATT, CSF_ADDR_FAULTS, CSF_ADDR_SHORT_CFG});
    assign wr_cfg = reg_wr && reg_addr == CSF_ADDR_SHORT_CFG;
    assign clr_sh = reg_wr && reg_addr == CSF_ADDR_FAULTS
        && reg_wdata[CSF_POS_SHORT];

    AST_RESET_CFG: assert property ($rose(rst_n) |->
        short_timeout_select == 3'h4 && short_voltage_select == 3'h4)
        else $error("config not at reset value");
    AST_IRQ_SET: assert property (
        $changed(charger_state) && mode_change_irq_enable
        |=> mode_change_irq) else $error("missing mode change pulse");
    AST_IRQ_ONLY: assert property (mode_change_irq |->
        $past(charger_state) != $past(charger_state, 2)
        && $past(mode_change_irq_enable))
        else $error("mode change pulse without cause");
    AST_FLT_READ: assert property (rd_flt |=>
        reg_rdata[CSF_POS_SHORT] == $past(shorted_cell_fault))
        else $error("fault read disagrees with short flag");
    AST_FLT_UNUSED: assert property (rd_flt |=>
        (reg_rdata & ~CSF_FAULT_MASK) == 8'h00)
        else $error("unused fault bits not zero");
    AST_UNMAPPED: assert property (rd_bad |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    AST_CFG_READ: assert property (rd_cfg |=> reg_rdata ==
        {$past(short_timeout_select), 2'h0, $past(short_voltage_select)})
        else $error("config read mismatch");
    AST_CFG_WRITE: assert property (wr_cfg |=>
        short_timeout_select == $past(reg_wdata[7:5])
        && short_voltage_select == $past(reg_wdata[2:0]))
        else $error("config write not taken");
    AST_CFG_STABLE: assert property (!wr_cfg |=>
        $stable(short_timeout_select) && $stable(short_voltage_select))
        else $error("config changed without write");
    AST_SHORT_HOLD: assert property (
        shorted_cell_fault && !clr_sh && !supply_power_lost
        |=> shorted_cell_fault) else $error("short flag dropped");
    AST_POWER_CLEAR: assert property (
        supply_power_lost |=> !shorted_cell_fault)
        else $error("power loss did not clear short flag");

    cover property (mode_change_irq);
    cover property ($rose(shorted_cell_fault));
    cover property (clr_sh && shorted_cell_fault);
endmodule
bind csf_charger_status_fault_regs csf_regs_asserts u_csf_regs_asserts (
    .clock, .rst_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
    .charger_state, .supply_power_lost, .mode_change_irq_enable,
    .mode_change_irq, .shorted_cell_fault, .short_timeout_select,
    .short_voltage_select
);
`default_nettype wire

// ---- verif/csf_host_model.sv ----
// host side of the byte register port
`timescale 1ns/1ps
`default_nettype none
module csf_host_model (
    input wire logic clock,
    input wire logic [7:0] reg_rdata,
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic [7:0] reg_wdata,
    output logic reg_rd
);
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        reg_rd = 1'b0;
    end
    // idle bus shows inverted data so stale values never pass
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        @(posedge clock);
        #1 d = reg_rdata;
    endtask
endmodule
`default_nettype wire

// ---- verif/tb.sv ----
// self-checking bench for the charger status and fault register bank
`timescale 1ns/1ps
`default_nettype none
module tb
    import csf_pkg::*;
;
    typedef struct packed {
        logic [3:0] fl;
        logic [2:0] st, zn, cl;
        logic ard, bl;
        logic [7:0] e0, e1;
    } csf_row_t;
    localparam csf_row_t ROWS [10] = '{
        '{4'h8, 3'h0, 3'h0, 3'h0, 1'b0, 1'b0, 8'h80, 8'h00},
        '{4'h4, 3'h1, 3'h1, 3'h1, 1'b0, 1'b0, 8'h41, 8'h21},
        '{4'h2, 3'h2, 3'h2, 3'h2, 1'b0, 1'b0, 8'h22, 8'h42},
        '{4'h1, 3'h3, 3'h3, 3'h3, 1'b1, 1'b1, 8'h13, 8'h63},
        '{4'h0, 3'h4, 3'h4, 3'h4, 1'b1, 1'b1, 8'h04, 8'h8c},
        '{4'hf, 3'h5, 3'h7, 3'h0, 1'b0, 1'b1, 8'hf5, 8'he0},
        '{4'h0, 3'h6, 3'h0, 3'h1, 1'b1, 1'b1, 8'h06, 8'h01},
        '{4'h0, 3'h7, 3'h0, 3'h2, 1'b0, 1'b0, 8'h07, 8'h02},
        '{4'h0, 3'h4, 3'h0, 3'h0, 1'b1, 1'b0, 8'h04, 8'h00},
        '{4'h0, 3'h4, 3'h0, 3'h0, 1'b0, 1'b1, 8'h04, 8'h00}};
    logic clock, rst_n, wr, rd, cend, ard, bl, lo, hi, pl, ien;
    logic irq, shf;
    logic [7:0] addr, wd, rdata, v;
    logic [3:0] fl;
    logic [2:0] st, zn, cl, tsel, vsel;
    logic [11:0] mv;
    int n_mismatch = 0;
    int samples_checked = 0;

    csf_charger_status_fault_regs #(.SECOND_CYCLES(4))
        u_csf_charger_status_fault_regs (
        .clock(clock), .rst_n(rst_n), .reg_addr(addr), .reg_wr(wr),
        .reg_wdata(wd), .reg_rd(rd), .reg_rdata(rdata),
        .input_overvoltage_flag(fl[3]), .input_valid_flag(fl[2]),
        .input_current_limited_flag(fl[1]), .die_heat_limited_flag(fl[0]),
        .charger_state(st), .charge_cycle_end(cend),
        .thermistor_zone_field(zn), .battery_class(cl),
        .auto_recharge_disable(ard), .below_recharge_level(bl),
        .battery_mv(mv), .lower_overheat_event(lo),
        .upper_overheat_event(hi), .supply_power_lost(pl),
        .mode_change_irq_enable(ien), .mode_change_irq(irq),
        .shorted_cell_fault(shf), .short_timeout_select(tsel),
        .short_voltage_select(vsel));
    csf_host_model u_csf_host_model (.clock(clock), .reg_rdata(rdata),
        .reg_addr(addr), .reg_wr(wr), .reg_wdata(wd), .reg_rd(rd));

    task automatic chk(input string nm, input logic [7:0] e,
        input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        u_csf_host_model.rd(a, v);
        chk($sformatf("reg %h", a), e, v);
    endtask
    task automatic report_and_stop();
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // whole run needs about 240 cycles
    initial begin
        cyc(20000);
        n_mismatch++;
        report_and_stop();
    end

    initial begin
        {rst_n, cend, ard, bl, lo, hi, pl, ien, fl, st, zn, cl} = '0;
        mv = 12'hfa0;
        cyc(10);
        rst_n <= 1'b1;
        cyc(1);
        #1 chk("tsel", 8'h04, {5'h0, tsel});
        chk("vsel", 8'h04, {5'h0, vsel});
        rdchk(CSF_ADDR_SHORT_CFG, 8'h84);
        rdchk(CSF_ADDR_FAULTS, 8'h00);
        foreach (ROWS[i]) begin
            @(posedge clock);
            {fl, st, zn, cl, ard, bl} <= ROWS[i][30:16];
            ien <= i[0];
            cyc(2);
            rdchk(CSF_ADDR_STATE_FLAGS, ROWS[i].e0);
            rdchk(CSF_ADDR_THERM_BATT, ROWS[i].e1);
        end
        // charge done must survive a drop under the recharge level
        @(posedge clock);
        {fl, ard, bl, cend} <= 7'h01;
        @(posedge clock);
        {cend, bl} <= 2'h1;
        cyc(2);
        rdchk(CSF_ADDR_STATE_FLAGS, 8'h0c);
        u_csf_host_model.wr(CSF_ADDR_STATE_FLAGS, 8'hff);
        rdchk(CSF_ADDR_STATE_FLAGS, 8'h0c);
        @(posedge clock);
        {lo, hi} <= 2'h3;
        @(posedge clock);
        {lo, hi} <= 2'h0;
        rdchk(CSF_ADDR_FAULTS, 8'h03);
        u_csf_host_model.wr(CSF_ADDR_FAULTS, 8'h02);
        rdchk(CSF_ADDR_FAULTS, 8'h01);
        @(posedge clock);
        pl <= 1'b1;
        @(posedge clock);
        pl <= 1'b0;
        rdchk(CSF_ADDR_FAULTS, 8'h00);
        u_csf_host_model.wr(8'h0e, 8'hff);
        rdchk(8'h0e, 8'h00);
        for (int c = 0; c < 8; c++) begin
            u_csf_host_model.wr(CSF_ADDR_SHORT_CFG, {c[2:0], 2'h3, c[2:0]});
            rdchk(CSF_ADDR_SHORT_CFG, {c[2:0], 2'h0, c[2:0]});
            chk("tsel", c[7:0], {5'h0, tsel});
        end
        // 1 s of four cycles at a 2100 mV threshold
        u_csf_host_model.wr(CSF_ADDR_SHORT_CFG, 8'h01);
        @(posedge clock);
        st <= 3'h1;
        mv <= 12'h834;
        cyc(20);
        #1 chk("short at threshold", 8'h00, {7'h0, shf});
        mv <= 12'h833;
        cyc(3);
        #1 chk("short too early", 8'h00, {7'h0, shf});
        for (int k = 0; k < 10 && shf !== 1'b1; k++) begin
            cyc(1);
            #1;
        end
        chk("short set", 8'h01, {7'h0, shf});
        rdchk(CSF_ADDR_FAULTS, 8'h08);
        u_csf_host_model.wr(CSF_ADDR_FAULTS, 8'h08);
        cyc(12);
        rdchk(CSF_ADDR_FAULTS, 8'h00);
        mv <= 12'hfa0;
        cyc(2);
        // state change with the interrupt enabled gives one pulse
        @(posedge clock);
        ien <= 1'b1;
        st <= 3'h5;
        @(posedge clock);
        #1 chk("irq on", 8'h01, {7'h0, irq});
        @(posedge clock);
        #1 chk("irq end", 8'h00, {7'h0, irq});
        @(posedge clock);
        ien <= 1'b0;
        st <= 3'h6;
        @(posedge clock);
        #1 chk("irq masked", 8'h00, {7'h0, irq});
        cyc(2);
        report_and_stop();
    end
endmodule
`default_nettype wire
